//--- hdl/cff_pkg.sv
package cff_pkg;
  localparam int DW = 16;
  localparam int AW = 8;
  localparam int ALARM_N = 5;
  localparam int PTR_W = 3;
  localparam int BUF_DEPTH = 8;

  // Device register offsets
  localparam logic [7:0] DEV_GENERAL = 8'h00;
  localparam logic [7:0] DEV_SHUTOFF = 8'h02;
  localparam logic [7:0] DEV_STATUS = 8'h05;
  localparam logic [7:0] DEV_MASK = 8'h07;

  // Alarm bit positions
  localparam int AL_CONV_LOST = 0;
  localparam int AL_DATA_LOST = 1;
  localparam int AL_NEAR_TWO = 2;
  localparam int AL_NEAR_ONE = 3;
  localparam int AL_COLLIDE = 4;

  // General configuration bits
  localparam int GEN_SW_TXEN = 0;
  localparam int GEN_RESYNC = 1;
  localparam int GEN_ALERT_HIGH = 3;

  localparam logic [15:0] GEN_RST = 16'h0009;
  localparam logic [4:0] MASK_RST = 5'h1f;
  localparam logic [4:0] SHUTOFF_RST = 5'h00;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [15:0] MID_CODE = 16'h8000;
  localparam logic [2:0] RESYNC_WR_PTR = 3'h4;
  localparam logic [2:0] NEAR_ONE_GAP = 3'h1;
  localparam logic [2:0] NEAR_TWO_GAP = 3'h2;
  localparam logic [2:0] LOST_EDGES = 3'h4;

  // Host register offsets and bits
  localparam logic [7:0] HOST_CTRL = 8'h00;
  localparam logic [7:0] HOST_STAT = 8'h01;
  localparam logic [7:0] HOST_DEV_DATA = 8'h02;
  localparam logic [7:0] HOST_DEV_CMD = 8'h03;
  localparam logic [7:0] HOST_DEV_RDATA = 8'h04;
  localparam int CTRL_TXEN = 0;
  localparam int CTRL_CLK_RUN = 1;
  localparam int CTRL_ALERT_HIGH = 2;
  localparam int CMD_READ = 8;
  localparam logic [2:0] CTRL_RST = 3'h4;

  localparam int CLK_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam logic [3:0] LINK_HALF_CYC = 4'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));

  typedef enum logic [1:0] {
    CFF_IDLE = 2'b00,
    CFF_ISSUE = 2'b01,
    CFF_WAIT = 2'b11
  } cff_host_st_e;
endpackage

//--- hdl/cff_link_if.sv
`timescale 1ns/1ns
interface cff_link_if;
  logic link_clk;
  logic [15:0] link_data;
  logic tx_enable;
  logic alert;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;

  modport device(
    input link_clk, link_data, tx_enable, reg_addr, reg_wdata, reg_wr, reg_rd,
    output alert, reg_rdata
  );
  modport host(
    output link_clk, link_data, tx_enable, reg_addr, reg_wdata, reg_wr, reg_rd,
    input alert, reg_rdata
  );
endinterface

//--- hdl/cff_loss_det.sv
`timescale 1ns/1ns
module cff_loss_det (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Edge pulses of the watched and the reference clock
  input wire logic mon_edge,
  input wire logic ref_edge,
  // Level while the watched clock is absent
  output logic lost
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic lost_q;

  assign cnt_d = mon_edge ? 3'h0 :
                 (ref_edge && cnt_q != cff_pkg::LOST_EDGES) ? cnt_q + 3'h1 : cnt_q;
  assign lost = lost_q;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cnt_q <= 3'h0;
      lost_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      lost_q <= (cnt_d == cff_pkg::LOST_EDGES);
    end
  end
endmodule

//--- hdl/cff_device.sv
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module cff_device (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Link to the host
  cff_link_if.device link,
  // Converter side
  input wire logic conv_clk,
  output logic [15:0] dac_code,
  output logic dac_on
);
  // Synchronisers for link clock, link data, transmit enable and conversion clock
  logic [1:0] lclk_s;
  logic [1:0] conv_s;
  logic [1:0] txen_s;
  logic [15:0] ldata_s1;
  logic [15:0] ldata_s2;
  logic lclk_prev_q;
  logic conv_prev_q;

  // Registers
  logic [15:0] general_q;
  logic [4:0] shutoff_q;
  logic [4:0] mask_q;
  logic [4:0] status_q;
  logic [4:0] status_d;
  logic [15:0] rdata_q;
  logic alert_q;

  // Buffer
  localparam int BUF_DEPTH_L = cff_pkg::BUF_DEPTH;
  logic [15:0] mem_q [BUF_DEPTH_L];
  logic [2:0] wr_q;
  logic [2:0] rd_q;
  logic [15:0] dac_code_q;
  logic [15:0] dac_code_d;
  logic dac_on_q;

  function automatic logic [2:0] cff_gap(input logic [2:0] a, input logic [2:0] b);
    logic [2:0] f;
    logic [2:0] r;
    f = a - b;
    r = b - a;
    cff_gap = (f < r) ? f : r;
  endfunction

  function automatic logic cff_hit(input logic [7:0] addr, input logic [7:0] off);
    cff_hit = (addr == off);
  endfunction

  // Edge detection, reading only second stages
  wire data_rise = lclk_s[1] & ~lclk_prev_q;
  wire conv_rise = conv_s[1] & ~conv_prev_q;

  // Register decode
  wire wr_gen = link.reg_wr & cff_hit(link.reg_addr, cff_pkg::DEV_GENERAL);
  wire wr_shut = link.reg_wr & cff_hit(link.reg_addr, cff_pkg::DEV_SHUTOFF);
  wire wr_stat = link.reg_wr & cff_hit(link.reg_addr, cff_pkg::DEV_STATUS);
  wire wr_mask = link.reg_wr & cff_hit(link.reg_addr, cff_pkg::DEV_MASK);
  wire resync = wr_gen & link.reg_wdata[cff_pkg::GEN_RESYNC];

  wire [1:0] mon_edges = {data_rise, conv_rise};
  wire [1:0] ref_edges = {conv_rise, data_rise};
  wire [1:0] lost;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_loss
      cff_loss_det u_det (
        .clock(clock),
        .reset_n(reset_n),
        .mon_edge(mon_edges[g]),
        .ref_edge(ref_edges[g]),
        .lost(lost[g])
      );
    end
  endgenerate

  // Pointer distance checks
  wire [2:0] gap = cff_gap(wr_q, rd_q);
  wire [4:0] events;
  assign events[cff_pkg::AL_CONV_LOST] = lost[0];
  assign events[cff_pkg::AL_DATA_LOST] = lost[1];
  assign events[cff_pkg::AL_NEAR_TWO] = (gap <= cff_pkg::NEAR_TWO_GAP);
  assign events[cff_pkg::AL_NEAR_ONE] = (gap <= cff_pkg::NEAR_ONE_GAP);
  assign events[cff_pkg::AL_COLLIDE] = (gap == 3'h0);

  // Sticky bits, set wins over clear
  assign status_d = (wr_stat ? (status_q & link.reg_wdata[4:0]) : status_q) | events;

  wire alarm_any = |(status_q & ~mask_q);

  wire tx_on = txen_s[1] & general_q[cff_pkg::GEN_SW_TXEN];
  wire [4:0] armed = status_q & shutoff_q;
  wire shut_hold = armed[cff_pkg::AL_CONV_LOST];
  // Mid code on data clock loss or pointer collision
  wire shut_mid = armed[cff_pkg::AL_DATA_LOST] | armed[cff_pkg::AL_COLLIDE];

  assign dac_code_d = shut_hold ? dac_code_q :
                      (shut_mid | ~tx_on) ? cff_pkg::MID_CODE :
                      conv_rise ? mem_q[rd_q] : dac_code_q;

  wire [15:0] rd_mux =
    cff_hit(link.reg_addr, cff_pkg::DEV_GENERAL) ? (general_q & 16'hfffd) :
    cff_hit(link.reg_addr, cff_pkg::DEV_SHUTOFF) ? {11'h000, shutoff_q} :
    cff_hit(link.reg_addr, cff_pkg::DEV_STATUS) ? {11'h000, status_q} :
    cff_hit(link.reg_addr, cff_pkg::DEV_MASK) ? {11'h000, mask_q} : 16'h0000;

  assign link.alert = alert_q;
  assign link.reg_rdata = rdata_q;
  assign dac_code = dac_code_q;
  assign dac_on = dac_on_q;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      lclk_s <= 2'h0;
      conv_s <= 2'h0;
      txen_s <= 2'h0;
      ldata_s1 <= 16'h0000;
      ldata_s2 <= 16'h0000;
      lclk_prev_q <= 1'b0;
      conv_prev_q <= 1'b0;
    end else begin
      lclk_s <= {lclk_s[0], link.link_clk};
      conv_s <= {conv_s[0], conv_clk};
      txen_s <= {txen_s[0], link.tx_enable};
      ldata_s1 <= link.link_data;
      ldata_s2 <= ldata_s1;
      lclk_prev_q <= lclk_s[1];
      conv_prev_q <= conv_s[1];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      general_q <= cff_pkg::GEN_RST;
      shutoff_q <= cff_pkg::SHUTOFF_RST;
      mask_q <= cff_pkg::MASK_RST;
      status_q <= cff_pkg::STATUS_RST;
      rdata_q <= 16'h0000;
    end else begin
      general_q <= wr_gen ? (link.reg_wdata & 16'hfffd) : general_q;
      shutoff_q <= wr_shut ? link.reg_wdata[4:0] : shutoff_q;
      mask_q <= wr_mask ? link.reg_wdata[4:0] : mask_q;
      status_q <= status_d;
      rdata_q <= link.reg_rd ? rd_mux : 16'h0000;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // Polarity reset is active high, so idle is low
      alert_q <= 1'b0;
    end else begin
      alert_q <= alarm_any ~^ general_q[cff_pkg::GEN_ALERT_HIGH];
    end
  end

  // Buffer storage, one entry written per data clock rising edge
  generate
    for (g = 0; g < BUF_DEPTH_L; g++) begin : g_mem
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          mem_q[g] <= 16'h0000;
        end else if (data_rise && wr_q == 3'(g)) begin
          mem_q[g] <= ldata_s2;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wr_q <= 3'h0;
      rd_q <= 3'h0;
    end else if (resync) begin
      wr_q <= cff_pkg::RESYNC_WR_PTR;
      rd_q <= 3'h0;
    end else begin
      wr_q <= data_rise ? wr_q + 3'h1 : wr_q;
      // Read side never waits for writes
      rd_q <= conv_rise ? rd_q + 3'h1 : rd_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dac_code_q <= cff_pkg::MID_CODE;
      dac_on_q <= 1'b0;
    end else begin
      dac_code_q <= dac_code_d;
      dac_on_q <= tx_on & ~shut_hold & ~shut_mid;
    end
  end
endmodule

//--- hdl/cff_host.sv
`timescale 1ns/1ns
module cff_host (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Link to the device
  cff_link_if.host link,
  // Command port
  input wire logic [7:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [15:0] cmd_rdata,
  // Sample stream
  input wire logic [15:0] sample_in,
  output logic sample_take,
  // Alert seen, already polarity corrected
  output logic alert_active
);
  cff_pkg::cff_host_st_e st_q;
  logic [2:0] ctrl_q;
  logic [15:0] dev_data_q;
  logic [15:0] dev_rdata_q;
  logic [7:0] dev_addr_q;
  logic clean_q;
  logic [1:0] al_s;
  logic al_prev_q;
  logic [15:0] cmd_rdata_q;
  logic [7:0] reg_addr_q;
  logic [15:0] reg_wdata_q;
  logic reg_wr_q;
  logic reg_rd_q;
  logic [3:0] div_q;
  logic lclk_q;
  logic [15:0] ldata_q;
  logic take_q;

  localparam logic [3:0] LINK_HALF_M1 = cff_pkg::LINK_HALF_CYC - 4'h1;

  wire alert_now = al_s[1] ~^ ctrl_q[cff_pkg::CTRL_ALERT_HIGH];
  wire alert_rise = alert_now & ~al_prev_q;
  wire wr_ctrl = cmd_wr & (cmd_addr == cff_pkg::HOST_CTRL);
  wire wr_data = cmd_wr & (cmd_addr == cff_pkg::HOST_DEV_DATA);
  wire wr_cmd = cmd_wr & (cmd_addr == cff_pkg::HOST_DEV_CMD) & (st_q == cff_pkg::CFF_IDLE);
  wire cmd_is_rd = cmd_wdata[cff_pkg::CMD_READ];
  wire rd_status = (dev_addr_q == cff_pkg::DEV_STATUS);
  wire div_wrap = (div_q == LINK_HALF_M1);
  wire run = ctrl_q[cff_pkg::CTRL_CLK_RUN];

  // Transmit enable only accepted when clean
  wire txen_set = wr_ctrl & cmd_wdata[cff_pkg::CTRL_TXEN] & clean_q;
  wire [2:0] ctrl_wr_val = {cmd_wdata[2:1], txen_set};

  wire [15:0] rd_mux =
    (cmd_addr == cff_pkg::HOST_CTRL) ? {13'h0000, ctrl_q} :
    (cmd_addr == cff_pkg::HOST_STAT) ? {13'h0000, clean_q, st_q != cff_pkg::CFF_IDLE, alert_now} :
    (cmd_addr == cff_pkg::HOST_DEV_DATA) ? dev_data_q :
    (cmd_addr == cff_pkg::HOST_DEV_RDATA) ? dev_rdata_q : 16'h0000;

  assign cmd_rdata = cmd_rdata_q;
  assign sample_take = take_q;
  assign alert_active = al_prev_q;
  assign link.link_clk = lclk_q;
  assign link.link_data = ldata_q;
  assign link.tx_enable = ctrl_q[cff_pkg::CTRL_TXEN];
  assign link.reg_addr = reg_addr_q;
  assign link.reg_wdata = reg_wdata_q;
  assign link.reg_wr = reg_wr_q;
  assign link.reg_rd = reg_rd_q;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      al_s <= 2'h0;
      al_prev_q <= 1'b0;
      ctrl_q <= cff_pkg::CTRL_RST;
      dev_data_q <= 16'h0000;
      cmd_rdata_q <= 16'h0000;
    end else begin
      al_s <= {al_s[0], link.alert};
      al_prev_q <= alert_now;
      dev_data_q <= wr_data ? cmd_wdata : dev_data_q;
      cmd_rdata_q <= cmd_rd ? rd_mux : 16'h0000;
      ctrl_q <= {wr_ctrl ? ctrl_wr_val[2:1] : ctrl_q[2:1],
                 ~alert_rise & (wr_ctrl ? ctrl_wr_val[0] : ctrl_q[0])};
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_q <= cff_pkg::CFF_IDLE;
      dev_addr_q <= 8'h00;
      dev_rdata_q <= 16'h0000;
      clean_q <= 1'b0;
      reg_addr_q <= 8'h00;
      reg_wdata_q <= 16'h0000;
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
    end else begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      clean_q <= alert_rise ? 1'b0 : clean_q;
      case (st_q)
        cff_pkg::CFF_IDLE: begin
          if (wr_cmd) begin
            dev_addr_q <= cmd_wdata[7:0];
            reg_addr_q <= cmd_wdata[7:0];
            reg_wdata_q <= dev_data_q;
            reg_wr_q <= ~cmd_is_rd;
            reg_rd_q <= cmd_is_rd;
            st_q <= cmd_is_rd ? cff_pkg::CFF_ISSUE : cff_pkg::CFF_IDLE;
          end
        end
        cff_pkg::CFF_ISSUE: begin
          st_q <= cff_pkg::CFF_WAIT;
        end
        cff_pkg::CFF_WAIT: begin
          dev_rdata_q <= link.reg_rdata;
          st_q <= cff_pkg::CFF_IDLE;
          if (rd_status) begin
            reg_wdata_q <= 16'h0000;
            reg_wr_q <= 1'b1;
            // Clean only once a read shows nothing
            clean_q <= ~alert_rise & (link.reg_rdata[4:0] == 5'h00);
          end
        end
        default: begin
          st_q <= cff_pkg::CFF_IDLE;
        end
      endcase
    end
  end

  // Link clock divider; samples change on the falling half
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      div_q <= 4'h0;
      lclk_q <= 1'b0;
      ldata_q <= 16'h0000;
      take_q <= 1'b0;
    end else begin
      div_q <= (!run || div_wrap) ? 4'h0 : div_q + 4'h1;
      lclk_q <= run & (div_wrap ? ~lclk_q : lclk_q);
      take_q <= run & div_wrap & lclk_q;
      ldata_q <= (run && div_wrap && lclk_q) ? sample_in : ldata_q;
    end
  end
endmodule

//--- test/cff_props.sv
`timescale 1ns/1ns
module cff_props (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Link signals
  input wire logic link_clk,
  input wire logic [15:0] link_data,
  input wire logic tx_enable,
  input wire logic alert,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  logic [5:0] cfg_q, cfg1_q, cfg2_q;
  logic rd_stat_q, clean_q, act_q, lclk_q;
  logic [7:0] idle_q;
  // Shadow of polarity and mask, so alert can be judged at the wire
  wire act = cfg_q[5] ? alert : ~alert;
  wire cfg_still = (cfg_q == cfg1_q) && (cfg1_q == cfg2_q);
  wire wr_gen = reg_wr && (reg_addr == cff_pkg::DEV_GENERAL);
  wire wr_mask = reg_wr && (reg_addr == cff_pkg::DEV_MASK);
  wire rd_stat = reg_rd && (reg_addr == cff_pkg::DEV_STATUS);
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cfg_q <= {cff_pkg::GEN_RST[3], cff_pkg::MASK_RST};
      cfg1_q <= {cff_pkg::GEN_RST[3], cff_pkg::MASK_RST};
      cfg2_q <= {cff_pkg::GEN_RST[3], cff_pkg::MASK_RST};
      rd_stat_q <= 1'b0;
      clean_q <= 1'b0;
      act_q <= 1'b0;
      lclk_q <= 1'b0;
      idle_q <= 8'h00;
    end else begin
      if (wr_gen) cfg_q[5] <= reg_wdata[3];
      if (wr_mask) cfg_q[4:0] <= reg_wdata[4:0];
      cfg1_q <= cfg_q;
      cfg2_q <= cfg1_q;
      rd_stat_q <= rd_stat;
      act_q <= act;
      lclk_q <= link_clk;
      // Saturates, so a long stop never wraps back to short
      idle_q <= (link_clk != lclk_q) ? 8'h00 : idle_q + {7'h00, idle_q != 8'hff};
      if (act && !act_q) clean_q <= 1'b0;
      else if (rd_stat_q) clean_q <= (reg_rdata[4:0] == 5'h00);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_mask_quiet; cfg_still && cfg_q[4:0] == 5'h1f |-> alert == !cfg_q[5]; endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("masked alarm on alert");
  property p_alert_map;
    rd_stat_q && cfg_still |-> act == (|(reg_rdata[4:0] & ~cfg_q[4:0]));
  endproperty
  a_alert_map: assert property (p_alert_map) else $error("alert not status OR");
  property p_clr_read;
    rd_stat |-> ##2 (reg_wr && reg_addr == cff_pkg::DEV_STATUS && reg_wdata == 16'h0000);
  endproperty
  a_clr_read: assert property (p_clr_read) else $error("status read not cleared");
  property p_txen_drop; $rose(act) |-> ##[1:8] !tx_enable; endproperty
  a_txen_drop: assert property (p_txen_drop) else $error("transmit kept on alert");
  property p_txen_clean; $rose(tx_enable) |-> clean_q; endproperty
  a_txen_clean: assert property (p_txen_clean) else $error("transmit before clean");
  property p_data_lost; rd_stat_q && idle_q > 8'h3c |-> reg_rdata[cff_pkg::AL_DATA_LOST];
  endproperty
  a_data_lost: assert property (p_data_lost) else $error("data clock loss missed");
  property p_near_chain;
    rd_stat_q |-> (!reg_rdata[4] || reg_rdata[3]) && (!reg_rdata[3] || reg_rdata[2]);
  endproperty
  a_near_chain: assert property (p_near_chain) else $error("gap flag order");
endmodule

//--- test/clock_fifo_fault_alarm_tb.sv
`timescale 1ns/1ns
module clock_fifo_fault_alarm_tb;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic conv_clk = 1'b0;
  logic conv_run = 1'b1;
  logic [1:0] conv_div = 2'h0;
  logic [7:0] cmd_addr = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [15:0] sample_in = 16'h0000;
  logic [15:0] cmd_rdata, dac_code, rd_v, held;
  logic sample_take, alert_active, dac_on;
  int bad_count = 0;
  int checks_done = 0;
  logic [7:0] ra [5] = '{cff_pkg::DEV_STATUS, cff_pkg::DEV_GENERAL, cff_pkg::DEV_SHUTOFF,
    cff_pkg::DEV_MASK, 8'h01};
  logic [15:0] rv [5] = '{16'h001e, cff_pkg::GEN_RST, 16'h0000, 16'h001f, 16'h0000};
  cff_link_if u_cff_link_if ();
  cff_device u_cff_device (.clock(clock), .reset_n(reset_n), .link(u_cff_link_if.device),
    .conv_clk(conv_clk), .dac_code(dac_code), .dac_on(dac_on));
  cff_host u_cff_host (.clock(clock), .reset_n(reset_n), .link(u_cff_link_if.host),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_rdata(cmd_rdata), .sample_in(sample_in), .sample_take(sample_take),
    .alert_active(alert_active));
  cff_props u_cff_props (.clock(clock), .reset_n(reset_n),
    .link_clk(u_cff_link_if.link_clk), .link_data(u_cff_link_if.link_data),
    .tx_enable(u_cff_link_if.tx_enable), .alert(u_cff_link_if.alert),
    .reg_addr(u_cff_link_if.reg_addr), .reg_wdata(u_cff_link_if.reg_wdata),
    .reg_wr(u_cff_link_if.reg_wr), .reg_rd(u_cff_link_if.reg_rd),
    .reg_rdata(u_cff_link_if.reg_rdata));
  always #20 clock = ~clock;
  // Same rate as the link clock, so the pointer gap stays put
  always @(posedge clock) begin
    conv_div <= conv_div + 2'h1;
    if (conv_run && conv_div == 2'h1) conv_clk <= ~conv_clk;
  end
  always @(posedge clock) if (sample_take) sample_in <= sample_in + 16'h1111;
  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= 1'b1;
    @(posedge clock);
    cmd_wr <= 1'b0;
  endtask
  task automatic cmd_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    @(posedge clock);
    cmd_rd <= 1'b0;
    #1 d = cmd_rdata;
  endtask
  task automatic dev_write(input logic [7:0] a, input logic [15:0] d);
    cmd_write(cff_pkg::HOST_DEV_DATA, d);
    cmd_write(cff_pkg::HOST_DEV_CMD, {8'h00, a});
    repeat (6) @(posedge clock);
  endtask
  task automatic dev_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    cmd_write(cff_pkg::HOST_DEV_CMD, {8'h01, a});
    repeat (6) @(posedge clock);
    cmd_read(cff_pkg::HOST_DEV_RDATA, rd_v);
    check(rd_v & m, e);
  endtask
  task automatic ctrl_chk(input logic [15:0] m, input logic [15:0] e);
    cmd_read(cff_pkg::HOST_CTRL, rd_v);
    check(rd_v & m, e);
  endtask
  task automatic wait_alert(input logic lvl);
    int n;
    n = 0;
    #1;
    while (alert_active !== lvl && n < 400) begin
      @(posedge clock);
      #1;
      n++;
    end
    check({15'h0000, alert_active}, {15'h0000, lvl});
    if (alert_active !== lvl) stop_test();
  endtask
  task automatic recover();
    cmd_write(cff_pkg::HOST_CTRL, 16'h0006);
    repeat (40) @(posedge clock);
    dev_write(cff_pkg::DEV_GENERAL, 16'h000b);
    for (int i = 0; i < 8; i++) begin
      cmd_write(cff_pkg::HOST_DEV_CMD, {8'h01, cff_pkg::DEV_STATUS});
      repeat (6) @(posedge clock);
      cmd_read(cff_pkg::HOST_DEV_RDATA, rd_v);
      if (rd_v === 16'h0000) break;
    end
    check(rd_v, 16'h0000);
    wait_alert(1'b0);
    cmd_write(cff_pkg::HOST_CTRL, 16'h0007);
    ctrl_chk(16'h0001, 16'h0001);
    cmd_read(cff_pkg::HOST_STAT, rd_v);
    check(rd_v, 16'h0004);
    repeat (30) @(posedge clock);
    #1 check({15'h0000, dac_on}, 16'h0001);
    held = dac_code;
    repeat (16) @(posedge clock);
    #1 check({15'h0000, dac_code !== held}, 16'h0001);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1 check(dac_code, cff_pkg::MID_CODE);
    repeat (60) @(posedge clock);
    for (int i = 0; i < 5; i++) begin
      dev_chk(ra[i], 16'hffff, rv[i]);
    end
    dev_write(cff_pkg::DEV_MASK, 16'h001c);
    dev_write(cff_pkg::DEV_SHUTOFF, 16'h0003);
    recover();
    // Data clock stops while the conversion clock runs
    cmd_write(cff_pkg::HOST_CTRL, 16'h0005);
    wait_alert(1'b1);
    repeat (20) @(posedge clock);
    #1 check({15'h0000, dac_on}, 16'h0000);
    check(dac_code, cff_pkg::MID_CODE);
    ctrl_chk(16'h0001, 16'h0000);
    dev_chk(cff_pkg::DEV_STATUS, 16'h0003, 16'h0002);
    cmd_write(cff_pkg::HOST_CTRL, 16'h0005);
    ctrl_chk(16'h0001, 16'h0000);
    recover();
    // Conversion clock stops; output must freeze on its last code
    conv_run <= 1'b0;
    repeat (12) @(posedge clock);
    #1 held = dac_code;
    wait_alert(1'b1);
    repeat (20) @(posedge clock);
    #1 check(dac_code, held);
    check({15'h0000, dac_on}, 16'h0000);
    dev_chk(cff_pkg::DEV_STATUS, 16'h0001, 16'h0001);
    conv_run <= 1'b1;
    recover();
    // Active-low alert: idle level high, then low on a fault
    dev_write(cff_pkg::DEV_MASK, 16'h001f);
    cmd_write(cff_pkg::HOST_CTRL, 16'h0002);
    dev_write(cff_pkg::DEV_GENERAL, 16'h0001);
    wait_alert(1'b0);
    check({15'h0000, u_cff_link_if.alert}, 16'h0001);
    dev_write(cff_pkg::DEV_MASK, 16'h001d);
    cmd_write(cff_pkg::HOST_CTRL, 16'h0000);
    wait_alert(1'b1);
    check({15'h0000, u_cff_link_if.alert}, 16'h0000);
    stop_test();
  end
endmodule
